// >>> hsps_regs.svh
// What this block does
// - After input rises above undervoltage level, keep switch off for insertion delay.
// - After insertion delay, sample enable; high level lets the switch start conducting.
// - While enable is held low, the pass switch stays off.
// - Input overvoltage turns the output off well inside 1.57 us.
// - In steady state, current above 1.5x fixed trip cuts output within 200 ns.
// - Current above 3x programmed threshold cuts output within 400 ns.
// - Moderate overcurrent trips only after 400 us or 3.2 ms blanking.
// - After start-up, current and input are watched and current kept limited.
// - Short supply transients are filtered; only sustained supply faults trip.
// - Junction over-temperature turns the pass switch off.
// - Switch not fully on within start-up timeout drives fault low, latch or retry.
// - Enable between shutdown and undervoltage levels past timer starts discharge.
// - Enable below shutdown level clears all sequencing state and latched faults; the input filters keep their levels.
// - When overvoltage clears, the switch turns back on through the slew ramp.
`ifndef HSPS_REGS_SVH
`define HSPS_REGS_SVH
`define HSPS_CLK_PERIOD_NS 5
`define HSPS_T_INS_US 13700
`define HSPS_T_OVP_NS 1570
`define HSPS_T_OVF_NS 1000
`define HSPS_T_UVF_NS 1000
`define HSPS_T_FFT_NS 200
`define HSPS_T_SFT_NS 400
`define HSPS_T_BLANK_US 400
`define HSPS_T_BLANK_LONG_US 3200
`define HSPS_T_RETRY_US 105000
`define HSPS_T_EN_DG_US 6
`define HSPS_T_SU_US 215000
`define HSPS_T_DSCHG_US 4660
`define HSPS_T_PGA_US 20
`define HSPS_CNT_W 32
`define HSPS_FILT_W 16
`endif

// >>> hsps_pkg.sv
`include "hsps_regs.svh"
package hsps_pkg;
  typedef enum logic [2:0] {
    HSPS_OFF = 3'h0,
    HSPS_INS = 3'h1,
    HSPS_WAIT_EN = 3'h2,
    HSPS_RAMP = 3'h3,
    HSPS_ON = 3'h4,
    HSPS_FAULT = 3'h5,
    HSPS_OVLO = 3'h6
  } hsps_state_t;

  typedef logic [`HSPS_CNT_W-1:0] hsps_cnt_t;

  // Rounds up so a timed wait is never short
  function automatic int hsps_ns2cyc(longint ns);
    return int'((ns + `HSPS_CLK_PERIOD_NS - 1) / `HSPS_CLK_PERIOD_NS);
  endfunction
endpackage

// >>> hsps_lvl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hsps_lvl_if;
  logic raw;
  logic level;
  modport flt (input raw, output level);
  modport usr (output raw, input level);
endinterface
`default_nettype wire

// >>> hsps_filt.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsps_regs.svh"
module hsps_filt #(
  parameter int CYC = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin in, filtered level out
  hsps_lvl_if.flt lvl
);
  import hsps_pkg::*;
  logic s1_q;
  logic s2_q;
  logic lvl_q;
  logic lvl_d;
  logic [`HSPS_FILT_W-1:0] cnt_q;
  logic [`HSPS_FILT_W-1:0] cnt_d;

  // A level must hold CYC cycles before it is believed
  always_comb
  begin
    lvl_d = lvl_q;
    cnt_d = '0;
    if (s2_q != lvl_q)
    begin
      if (cnt_q == `HSPS_FILT_W'(CYC - 1))
        lvl_d = s2_q;
      else
        cnt_d = cnt_q + `HSPS_FILT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      s1_q <= lvl.raw;
      s2_q <= s1_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign lvl.level = lvl_q;
endmodule
`default_nettype wire

// >>> hsps_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsps_regs.svh"
module hsps_top #(
  parameter int INS_CYC = hsps_pkg::hsps_ns2cyc(`HSPS_T_INS_US * 1000),
  parameter int BLANK_CYC = hsps_pkg::hsps_ns2cyc(`HSPS_T_BLANK_US * 1000),
  parameter int BLANK_LONG_CYC =
    hsps_pkg::hsps_ns2cyc(`HSPS_T_BLANK_LONG_US * 1000),
  parameter int RETRY_CYC = hsps_pkg::hsps_ns2cyc(`HSPS_T_RETRY_US * 1000),
  parameter int SU_CYC = hsps_pkg::hsps_ns2cyc(64'(`HSPS_T_SU_US) * 1000),
  parameter int DSCHG_CYC = hsps_pkg::hsps_ns2cyc(`HSPS_T_DSCHG_US * 1000)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Supply and enable comparators
  input wire logic vin_above_uvp,
  input wire logic vin_above_ovp,
  input wire logic enable_undervoltage_input,
  input wire logic en_above_shutdown,
  // Current, temperature and switch-state comparators
  input wire logic iout_above_fft,
  input wire logic iout_above_sft,
  input wire logic iout_above_ocp,
  input wire logic temp_shutdown,
  input wire logic fet_fully_on,
  // Configuration straps
  input wire logic cfg_auto_retry,
  input wire logic cfg_long_blank,
  // Switch control and indications
  output logic fet_gate_on,
  output logic slew_ramp_control,
  output logic current_limit_active,
  output logic fault_indication_output_n,
  output logic power_good_output,
  output logic quick_output_discharge
);
  import hsps_pkg::*;
  localparam int EN_DG_CYC = hsps_ns2cyc(`HSPS_T_EN_DG_US * 1000);
  localparam int OVF_CYC = hsps_ns2cyc(`HSPS_T_OVF_NS);
  localparam int UVF_CYC = hsps_ns2cyc(`HSPS_T_UVF_NS);
  localparam int PGA_CYC = hsps_ns2cyc(`HSPS_T_PGA_US * 1000);

  hsps_lvl_if en_f ();
  hsps_lvl_if ov_f ();
  hsps_lvl_if uv_f ();
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic sd_s;
  logic ffft_s;
  logic sft_s;
  logic ocp_s;
  logic ot_s;
  logic full_s;
  logic auto_s;
  logic longb_s;
  logic rst_core;
  hsps_state_t st_q;
  hsps_state_t st_d;
  hsps_cnt_t tmr_q;
  hsps_cnt_t tmr_d;
  hsps_cnt_t blk_q;
  hsps_cnt_t blk_d;
  hsps_cnt_t qcnt_q;
  hsps_cnt_t qcnt_d;
  logic blank_hit;
  logic between;
  logic fet_q, fet_d;
  logic slew_q, slew_d;
  logic ilim_q, ilim_d;
  logic fault_n_q, fault_n_d;
  logic pg_q, pg_d;
  logic dsch_q, dsch_d;

  function automatic hsps_cnt_t sat_inc(hsps_cnt_t v);
    return (v == '1) ? v : v + `HSPS_CNT_W'(1);
  endfunction

  function automatic logic hit(hsps_cnt_t v, int n);
    return v >= `HSPS_CNT_W'(n - 1);
  endfunction

  assign en_f.raw = enable_undervoltage_input;
  assign ov_f.raw = vin_above_ovp;
  assign uv_f.raw = vin_above_uvp;

  hsps_filt #(.CYC(EN_DG_CYC)) u_en_filt (
    .clk(sys_clk),
    .rst(srst),
    .lvl(en_f.flt)
  );
  hsps_filt #(.CYC(OVF_CYC)) u_ov_filt (
    .clk(sys_clk),
    .rst(srst),
    .lvl(ov_f.flt)
  );
  hsps_filt #(.CYC(UVF_CYC)) u_uv_filt (
    .clk(sys_clk),
    .rst(srst),
    .lvl(uv_f.flt)
  );

  // Fast paths are synchronised only; a filter would eat the trip budget
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end
    else
    begin
      s1_q <= {en_above_shutdown, iout_above_fft, iout_above_sft,
               iout_above_ocp, temp_shutdown, fet_fully_on,
               cfg_auto_retry, cfg_long_blank};
      s2_q <= s1_q;
    end
  end
  assign {sd_s, ffft_s, sft_s, ocp_s, ot_s, full_s, auto_s, longb_s} = s2_q;

  // Deep shutdown wipes all sequencing state and latched faults
  assign rst_core = srst | ~sd_s;

  assign blank_hit = hit(blk_q, longb_s ? BLANK_LONG_CYC : BLANK_CYC);

  always_comb
  begin
    st_d = st_q;
    if (!uv_f.level)
      st_d = HSPS_OFF;
    else
      case (st_q)
        HSPS_OFF: st_d = HSPS_INS;
        HSPS_INS: if (hit(tmr_q, INS_CYC)) st_d = HSPS_WAIT_EN;
        HSPS_WAIT_EN:
          if (en_f.level && !ov_f.level && !ot_s)
            st_d = HSPS_RAMP;
        HSPS_RAMP:
          if (!en_f.level)
            st_d = HSPS_WAIT_EN;
          else if (ov_f.level)
            st_d = HSPS_OVLO;
          else if (ot_s || sft_s || hit(tmr_q, SU_CYC))
            st_d = HSPS_FAULT;
          else if (full_s)
            st_d = HSPS_ON;
        HSPS_ON:
          if (!en_f.level)
            st_d = HSPS_WAIT_EN;
          else if (ov_f.level)
            st_d = HSPS_OVLO;
          else if (ot_s || sft_s || ffft_s || blank_hit)
            st_d = HSPS_FAULT;
        HSPS_OVLO:
          if (!en_f.level)
            st_d = HSPS_WAIT_EN;
          else if (!ov_f.level && !ot_s)
            st_d = HSPS_RAMP;
        HSPS_FAULT:
          if (auto_s && hit(tmr_q, RETRY_CYC))
            st_d = HSPS_WAIT_EN;
        default: st_d = HSPS_OFF;
      endcase
    tmr_d = (st_d != st_q) ? '0 : sat_inc(tmr_q);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_core)
    begin
      st_q <= HSPS_OFF;
      tmr_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
    end
  end

  // Blanking restarts on every dip so short peaks never trip
  // Discharge counts only in the band between shutdown and undervoltage
  assign between = sd_s & ~en_f.level;
  always_comb
  begin
    blk_d = (st_q == HSPS_ON && ocp_s) ? sat_inc(blk_q) : '0;
    qcnt_d = between ? sat_inc(qcnt_q) : '0;
    dsch_d = between && (dsch_q || hit(qcnt_q, DSCHG_CYC));
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_core)
    begin
      blk_q <= '0;
      qcnt_q <= '0;
      dsch_q <= 1'b0;
    end
    else
    begin
      blk_q <= blk_d;
      qcnt_q <= qcnt_d;
      dsch_q <= dsch_d;
    end
  end

  always_comb
  begin
    fet_d = (st_d == HSPS_RAMP || st_d == HSPS_ON);
    slew_d = (st_d == HSPS_RAMP);
    ilim_d = fet_d && ocp_s;
    fault_n_d = (st_d != HSPS_FAULT);
    pg_d = (st_q == HSPS_ON && st_d == HSPS_ON &&
            hit(tmr_q, PGA_CYC));
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_core)
    begin
      fet_q <= 1'b0;
      slew_q <= 1'b0;
      ilim_q <= 1'b0;
      fault_n_q <= 1'b1;
      pg_q <= 1'b0;
    end
    else
    begin
      fet_q <= fet_d;
      slew_q <= slew_d;
      ilim_q <= ilim_d;
      fault_n_q <= fault_n_d;
      pg_q <= pg_d;
    end
  end

  assign fet_gate_on = fet_q;
  assign slew_ramp_control = slew_q;
  assign current_limit_active = ilim_q;
  assign fault_indication_output_n = fault_n_q;
  assign power_good_output = pg_q;
  assign quick_output_discharge = dsch_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst_core);

  logic calm;
  assign calm = uv_f.level && en_f.level && !ov_f.level && !ot_s &&
                !sft_s && !ffft_s;

  sequence s_ins_done;
    st_q == HSPS_INS && st_d == HSPS_WAIT_EN;
  endsequence
  sequence s_peak;
    (st_q == HSPS_ON && !ocp_s) ##1 (calm && ocp_s && st_q == HSPS_ON)[*8];
  endsequence
  sequence s_ovp_clear;
    st_q == HSPS_OVLO && uv_f.level && en_f.level && !ov_f.level && !ot_s;
  endsequence

  property p_ins_delay;
    s_ins_done |-> tmr_q == `HSPS_CNT_W'(INS_CYC - 1) && !fet_q;
  endproperty
  a_ins_delay: assert property (p_ins_delay)
    else $error("insertion delay length wrong");
  property p_en_start;
    (st_q == HSPS_WAIT_EN && calm) |=> fet_q && slew_q;
  endproperty
  a_en_start: assert property (p_en_start)
    else $error("enable high did not start ramp");
  property p_en_off;
    !en_f.level |=> !fet_q;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("switch on while enable low");
  property p_ovp_off;
    (ov_f.level && fet_q) |=> !fet_q;
  endproperty
  a_ovp_off: assert property (p_ovp_off)
    else $error("switch stayed on in overvoltage");
  property p_fft;
    (st_q == HSPS_ON && ffft_s) |=> !fet_q;
  endproperty
  a_fft: assert property (p_fft)
    else $error("fixed fast trip missed");
  property p_sft;
    (fet_q && sft_s) |=> !fet_q ##1 !fet_q;
  endproperty
  a_sft: assert property (p_sft)
    else $error("scalable fast trip missed");
  property p_peak_pass;
    s_peak |=> st_q == HSPS_ON && fet_q;
  endproperty
  a_peak_pass: assert property (p_peak_pass)
    else $error("short current peak tripped");
  property p_ot;
    ot_s |=> !fet_q;
  endproperty
  a_ot: assert property (p_ot)
    else $error("switch on in over-temperature");
  property p_pg_delay;
    $rose(pg_q) |-> st_q == HSPS_ON && tmr_q >= `HSPS_CNT_W'(PGA_CYC);
  endproperty
  a_pg_delay: assert property (p_pg_delay)
    else $error("power good asserted too early");
  property p_retry;
    (st_q == HSPS_FAULT && auto_s && uv_f.level &&
     tmr_q == `HSPS_CNT_W'(RETRY_CYC - 1)) |=> st_q == HSPS_WAIT_EN;
  endproperty
  a_retry: assert property (p_retry)
    else $error("auto retry did not restart");
  property p_fault_pin;
    $rose(st_q == HSPS_FAULT) |-> !fault_n_q && !fet_q && !pg_q;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault state without fault pin low");
  // Output is registered, so it trails the band by one cycle
  property p_dsch;
    dsch_q |-> $past(between) && !fet_q;
  endproperty
  a_dsch: assert property (p_dsch)
    else $error("discharge outside enable band");
  property p_ovp_ramp;
    s_ovp_clear |=> st_q == HSPS_RAMP && slew_q && fet_q;
  endproperty
  a_ovp_ramp: assert property (p_ovp_ramp)
    else $error("no ramp after overvoltage cleared");
endmodule
`default_nettype wire

// >>> hsps_host.sv
`timescale 1ns/100ps
`default_nettype none
module hsps_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host intent
  input wire logic want_on,
  input wire logic deep_off,
  // Enable pins
  output var logic en_pin = 1'b0,
  output var logic sd_pin = 1'b1
);
  // Pins move only on the clock edge, like a host GPIO
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_pin <= 1'b0;
      sd_pin <= 1'b1;
    end
    else
    begin
      en_pin <= want_on & ~deep_off;
      sd_pin <= ~deep_off;
    end
  end
endmodule
`default_nettype wire

// >>> hsps_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module hsps_top_tb;
  import hsps_pkg::*;
  localparam int INS = 20;
  localparam int BLK = 30;
  localparam int BLKL = 60;
  localparam int RTY = 40;
  localparam int SU = 100;
  localparam int DSC = 25;
  localparam int FLT = 0;
  localparam int FET = 1;
  localparam int SLW = 2;
  localparam int PG = 3;
  localparam int QD = 4;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic uv = 1'b0, ov = 1'b0, ocp = 1'b0, full = 1'b0;
  logic auto = 1'b0, lng = 1'b0, want_on = 1'b0, deep_off = 1'b0;
  logic [2:0] trip = 3'h0;
  logic en_pin, sd_pin, fet, slew, ilim, fault_n, pg, dsch;
  logic [4:0] obs;
  int err_count = 0;
  int total_checks = 0;
  assign obs = {dsch, pg, slew, fet, fault_n};
  hsps_host host_u (.sys_clk(sys_clk), .srst(srst), .want_on(want_on),
    .deep_off(deep_off), .en_pin(en_pin), .sd_pin(sd_pin));
  hsps_top #(.INS_CYC(INS), .BLANK_CYC(BLK), .BLANK_LONG_CYC(BLKL),
    .RETRY_CYC(RTY), .SU_CYC(SU), .DSCHG_CYC(DSC)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .vin_above_uvp(uv),
    .vin_above_ovp(ov), .enable_undervoltage_input(en_pin),
    .en_above_shutdown(sd_pin), .iout_above_fft(trip[0]),
    .iout_above_sft(trip[1]), .iout_above_ocp(ocp),
    .temp_shutdown(trip[2]), .fet_fully_on(full),
    .cfg_auto_retry(auto), .cfg_long_blank(lng), .fet_gate_on(fet),
    .slew_ramp_control(slew), .current_limit_active(ilim),
    .fault_indication_output_n(fault_n), .power_good_output(pg),
    .quick_output_discharge(dsch));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Settled sampling one step after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_o(input int s, input logic v, input int mx,
    output int n);
    n = 0;
    while (obs[s] !== v && n <= mx)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Deep shutdown pulse, then restart up to the ramp or to full on
  task automatic bring_up(input logic with_full);
    int n;
    @(posedge sys_clk);
    full <= 1'b0;
    deep_off <= 1'b1;
    cyc(6);
    chk(fault_n, 1'b1);
    chk(fet, 1'b0);
    @(posedge sys_clk);
    deep_off <= 1'b0;
    wait_o(FET, 1'b1, 400, n);
    chk(fet, 1'b1);
    if (with_full)
    begin
      @(posedge sys_clk);
      full <= 1'b1;
      cyc(8);
    end
  endtask
  task automatic t_start;
    int n;
    @(posedge sys_clk);
    want_on <= 1'b1;
    cyc(1300);
    chk(fet, 1'b0);
    @(posedge sys_clk);
    uv <= 1'b1;
    wait_o(FET, 1'b1, 400, n);
    chk(n >= INS + 200, 1'b1);
    chk(n <= INS + 210, 1'b1);
    chk(slew, 1'b1);
    @(posedge sys_clk);
    full <= 1'b1;
    cyc(3900);
    chk(slew, 1'b0);
    chk(pg, 1'b0);
    wait_o(PG, 1'b1, 300, n);
    chk(pg, 1'b1);
  endtask
  task automatic t_blank(input logic l, input int b);
    int n;
    @(posedge sys_clk);
    lng <= l;
    bring_up(1'b1);
    @(posedge sys_clk);
    ocp <= 1'b1;
    cyc(b - 10);
    chk(ilim, 1'b1);
    @(posedge sys_clk);
    ocp <= 1'b0;
    cyc(10);
    chk(fault_n, 1'b1);
    @(posedge sys_clk);
    ocp <= 1'b1;
    wait_o(FLT, 1'b0, b + 20, n);
    chk(n >= b - 6 && n <= b + 6, 1'b1);
    chk(fet, 1'b0);
    @(posedge sys_clk);
    ocp <= 1'b0;
    cyc(RTY + 20);
    chk(fault_n, 1'b0);
  endtask
  // Fixed fast trip, scalable fast trip, over-temperature
  task automatic t_fast;
    int n;
    int lim[3] = '{40, 80, 20};
    for (int k = 0; k < 3; k++)
    begin
      bring_up(1'b1);
      @(posedge sys_clk);
      trip[k] <= 1'b1;
      wait_o(FLT, 1'b0, lim[k], n);
      chk(n <= lim[k], 1'b1);
      chk(fet, 1'b0);
      @(posedge sys_clk);
      trip <= 3'h0;
    end
  endtask
  task automatic t_ovp;
    int n;
    bring_up(1'b1);
    @(posedge sys_clk);
    ov <= 1'b1;
    cyc(150);
    @(posedge sys_clk);
    ov <= 1'b0;
    cyc(220);
    chk(fet, 1'b1);
    @(posedge sys_clk);
    ov <= 1'b1;
    wait_o(FET, 1'b0, 314, n);
    chk(n <= 314, 1'b1);
    @(posedge sys_clk);
    full <= 1'b0;
    ov <= 1'b0;
    wait_o(SLW, 1'b1, 300, n);
    chk(slew, 1'b1);
    chk(fet, 1'b1);
    @(posedge sys_clk);
    full <= 1'b1;
    cyc(5);
  endtask
  task automatic t_su;
    int n;
    @(posedge sys_clk);
    auto <= 1'b1;
    bring_up(1'b0);
    wait_o(FLT, 1'b0, SU + 10, n);
    chk(n >= SU - 5 && n <= SU + 5, 1'b1);
    chk(fet, 1'b0);
    wait_o(FET, 1'b1, RTY + 10, n);
    chk(n >= RTY - 3 && n <= RTY + 5, 1'b1);
    chk(fault_n, 1'b1);
    @(posedge sys_clk);
    auto <= 1'b0;
  endtask
  task automatic t_en;
    int n;
    bring_up(1'b1);
    @(posedge sys_clk);
    want_on <= 1'b0;
    cyc(1000);
    @(posedge sys_clk);
    want_on <= 1'b1;
    cyc(1300);
    chk(fet, 1'b1);
    @(posedge sys_clk);
    want_on <= 1'b0;
    wait_o(FET, 1'b0, 1220, n);
    chk(n >= 1195 && n <= 1210, 1'b1);
    wait_o(QD, 1'b1, DSC + 10, n);
    chk(n >= DSC - 3, 1'b1);
    chk(n <= DSC + 3, 1'b1);
    chk(dsch, 1'b1);
    chk(fet, 1'b0);
    @(posedge sys_clk);
    want_on <= 1'b1;
    wait_o(QD, 1'b0, 1300, n);
    chk(dsch, 1'b0);
  endtask
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Whole run is near 12k cycles; allow about six and a half times that
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_start();
    t_blank(1'b0, BLK);
    t_blank(1'b1, BLKL);
    t_fast();
    t_ovp();
    t_su();
    t_en();
    report_and_stop();
  end
endmodule
`default_nettype wire
